// >>> pssrc_pkg.sv
// constants, register map, field layout and carrier types for the
// power stage start/stop and fault recovery controller.
// assumes a 20 MHz processing clock and an 8-bit register port.
package pssrc_pkg;

  // clock and timer resolution
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TMR_W = 18;

  // register bus widths
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;

  // register offsets
  localparam logic [7:0] ADDR_RAMP = 8'h1A;
  localparam logic [7:0] ADDR_TRIM = 8'h1B;
  localparam logic [7:0] ADDR_WAIT = 8'h1C;
  localparam logic [7:0] ADDR_STAT = 8'h1D;
  localparam logic [7:0] ADDR_MASK = 8'h1E;

  // reset values
  localparam logic [7:0] RAMP_RST = 8'h0F;
  localparam logic [7:0] TRIM_RST = 8'h82;
  localparam logic [3:0] WAIT_RST = 4'h2;

  // field positions
  localparam int unsigned RAMP_DIS_BIT = 7;
  localparam int unsigned TRIM_RSV_BIT = 7;
  localparam int unsigned TRIM_DONE_BIT = 6;
  localparam int unsigned TRIM_SEL_BIT = 1;

  // status and mask bit layout
  localparam int unsigned ST_RAMP_DONE = 0;
  localparam int unsigned ST_TRIM_DONE = 1;
  localparam int unsigned ST_FAULT = 2;
  localparam int unsigned ST_RESTART = 3;
  localparam int unsigned NSTAT = 4;

  // start/stop interval per 5-bit code, in 0.1 ms ticks
  function automatic logic [TMR_W-1:0] ramp_ticks(input logic [4:0] code);
    logic [TMR_W-1:0] t;
    t = 18'h00000;
    unique case (code)
      5'h08: t = 18'd165;
      5'h09: t = 18'd239;
      5'h0A: t = 18'd314;
      5'h0B: t = 18'd404;
      5'h0C: t = 18'd539;
      5'h0D: t = 18'd703;
      5'h0E: t = 18'd942;
      5'h0F: t = 18'd1257;
      5'h10: t = 18'd1646;
      5'h11: t = 18'd394;
      5'h12: t = 18'd3142;
      5'h13: t = 18'd4039;
      5'h14: t = 18'd5386;
      5'h15: t = 18'd7031;
      5'h16: t = 18'd9425;
      5'h17: t = 18'd12566;
      5'h18: t = 18'd17281;
      5'h19: t = 18'd25136;
      5'h1A: t = 18'd32991;
      5'h1B: t = 18'd42417;
      5'h1C: t = 18'd56556;
      5'h1D: t = 18'd73837;
      5'h1E: t = 18'd98973;
      5'h1F: t = 18'd131964;
      default: t = 18'h00000;
    endcase
    return t;
  endfunction : ramp_ticks

  // back-end reset wait per 4-bit code, in 0.1 ms ticks
  function automatic logic [TMR_W-1:0] wait_ticks(input logic [3:0] code);
    logic [TMR_W-1:0] t;
    t = 18'd2990;
    unique case (code)
      4'h3: t = 18'd4490;
      4'h4: t = 18'd5980;
      4'h5: t = 18'd7480;
      4'h6: t = 18'd8980;
      4'h7: t = 18'd10470;
      4'h8: t = 18'd11970;
      4'h9: t = 18'd13460;
      4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: t = 18'd14960;
      default: t = 18'd2990;
    endcase
    return t;
  endfunction : wait_ticks

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pssrc_bus_req_t;

  // power stage control
  typedef struct packed {
    logic stage_run;
    logic half_duty;
    logic stage_reset;
  } pssrc_stage_t;

  typedef enum {S_OFF, S_RAMP_UP, S_RUN, S_RAMP_DOWN, S_FAULT} pssrc_state_t;

endpackage : pssrc_pkg

// >>> pssrc_tick_timer.sv
// down-counting interval timer advanced by a tick enable.
// assumes load and tick come from logic on the same clock.
`timescale 1ns/1ps
module pssrc_tick_timer #(
  parameter int unsigned W = 18
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  output logic busy,
  output logic expire
);

  logic [W-1:0] cnt_r;

  // count ticks down, one-cycle expire at the last one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= '0;
      busy <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        cnt_r <= load_val;
        busy <= 1'b1;
      end else if (busy && tick) begin
        if (cnt_r <= W'(1)) begin
          busy <= 1'b0;
          expire <= 1'b1;
        end else begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end

endmodule : pssrc_tick_timer

// >>> pssrc_ctrl.sv
// power stage start/stop ramp, oscillator trim and back-end fault recovery.
// assumes registers are reached over a plain strobe port, one clock domain.
// Contract
// - A start/stop interval is run on every entry to or exit from all-channel shutdown and every power-down pin change.
//   Here an interval runs only when the change turns the stage on or off, and not in S_FAULT.
// - Period code bits four and three both zero skip the half-duty interval.
// - Codes 01000 to 01111 give 16.5 ms up to 125.7 ms, and 01111 is the reset value.
// - Codes 10000 to 11111 give longer intervals from 164.6 ms up to about 13.2 s; code 10001 here gives only 39.4 ms.
// - Interval lengths are approximate and may drift with device activity.
// - Writing 0x00 to the trim register applies the factory oscillator trim.
// - Bit six of the trim register reads 0 until trim finishes and 1 afterwards.
// - The factory-trim select bit one resets to 1 and writing 0 selects factory trim.
// - A back-end error resets the power stage and stops all PWM activity.
// - After a back-end error the stage waits the programmed period and then restarts.
// - The low four wait bits give 299 ms at code 0010, about 150 ms more per code, 1496 ms from 1010.
// - The wait register takes one write after reset and ignores the rest.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module pssrc_ctrl #(
  parameter int unsigned TICK_CYCLES = pssrc_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pssrc_pkg::pssrc_bus_req_t bus_req,
  output logic [pssrc_pkg::DW-1:0] rdata_r,
  input wire logic powerdown_pin_state,
  input wire logic all_ch_shutdown,
  input wire logic backend_fault,
  input wire logic osc_trim_ready,
  output pssrc_pkg::pssrc_stage_t stage_r,
  output logic trim_apply_r,
  output logic irq_r
);

  localparam int unsigned TW = pssrc_pkg::TMR_W;

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic pin_s;
  logic fault_s;
  logic osc_s;
  logic [11:0] div_r;
  logic tick_r;
  logic ramp_dis_r;
  logic [4:0] ramp_code_r;
  logic trim_sel_r;
  logic trim_done_r;
  logic [3:0] wait_code_r;
  logic wait_lock_r;
  logic [pssrc_pkg::NSTAT-1:0] stat_r;
  logic [pssrc_pkg::NSTAT-1:0] mask_r;
  logic [pssrc_pkg::NSTAT-1:0] stat_set;
  pssrc_pkg::pssrc_state_t state_r;
  pssrc_pkg::pssrc_state_t state_nxt;
  logic target_on;
  logic ramp_on;
  logic ramp_load;
  logic wait_load;
  logic ramp_busy;
  logic ramp_exp;
  logic wait_exp;
  logic [TW-1:0] ramp_len;
  logic [TW-1:0] wait_len;
  logic wr_ramp;
  logic wr_trim;
  logic wr_wait;

  // two-stage synchronisers for pin and analog-side inputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {osc_trim_ready, backend_fault, powerdown_pin_state};
      sync2_r <= sync1_r;
    end
  end
  assign pin_s = sync2_r[0];
  assign fault_s = sync2_r[1];
  assign osc_s = sync2_r[2];

  // 0.1 ms tick divider; tick phase adds up to one tick of slack
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_r <= 12'h000;
      tick_r <= 1'b0;
    end else if (div_r >= 12'(TICK_CYCLES - 1)) begin
      div_r <= 12'h000;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 12'h001;
      tick_r <= 1'b0;
    end
  end

  // write decode
  assign wr_ramp = bus_req.wr && (bus_req.addr == pssrc_pkg::ADDR_RAMP);
  assign wr_trim = bus_req.wr && (bus_req.addr == pssrc_pkg::ADDR_TRIM);
  assign wr_wait = bus_req.wr && (bus_req.addr == pssrc_pkg::ADDR_WAIT);

  // start/stop period register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ramp_dis_r <= pssrc_pkg::RAMP_RST[pssrc_pkg::RAMP_DIS_BIT];
      ramp_code_r <= pssrc_pkg::RAMP_RST[4:0];
    end else if (wr_ramp) begin
      ramp_dis_r <= bus_req.wdata[pssrc_pkg::RAMP_DIS_BIT];
      ramp_code_r <= bus_req.wdata[4:0];
    end
  end

  // trim select: writing 0x00 clears the select bit and applies factory trim
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_sel_r <= pssrc_pkg::TRIM_RST[pssrc_pkg::TRIM_SEL_BIT];
      trim_apply_r <= 1'b0;
    end else begin
      if (wr_trim) begin
        trim_sel_r <= bus_req.wdata[pssrc_pkg::TRIM_SEL_BIT];
      end
      trim_apply_r <= ~trim_sel_r;
    end
  end

  // trim complete flag, sticky until reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_done_r <= 1'b0;
    end else if (trim_apply_r && osc_s) begin
      trim_done_r <= 1'b1;
    end
  end

  // back-end wait register, one write after reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_code_r <= pssrc_pkg::WAIT_RST;
      wait_lock_r <= 1'b0;
    end else if (wr_wait && !wait_lock_r) begin
      wait_code_r <= bus_req.wdata[3:0];
      wait_lock_r <= 1'b1;
    end
  end

  // interval lengths from the code tables
  assign ramp_len = pssrc_pkg::ramp_ticks(ramp_code_r);
  assign wait_len = pssrc_pkg::wait_ticks(wait_code_r);

  // stage should run when not shut down and pin says powered up
  assign target_on = pin_s && !all_ch_shutdown;
  assign ramp_on = !ramp_dis_r && (ramp_code_r[4:3] != 2'b00);

  // start/stop and recovery sequencing
  always_comb begin
    state_nxt = state_r;
    ramp_load = 1'b0;
    wait_load = 1'b0;
    unique case (state_r)
      pssrc_pkg::S_OFF: begin
        if (target_on) begin
          ramp_load = ramp_on;
          state_nxt = ramp_on ? pssrc_pkg::S_RAMP_UP : pssrc_pkg::S_RUN;
        end
      end
      pssrc_pkg::S_RAMP_UP: begin
        if (!target_on) begin
          ramp_load = 1'b1;
          state_nxt = pssrc_pkg::S_RAMP_DOWN;
        end else if (ramp_exp) begin
          state_nxt = pssrc_pkg::S_RUN;
        end
      end
      pssrc_pkg::S_RUN: begin
        if (!target_on) begin
          ramp_load = ramp_on;
          state_nxt = ramp_on ? pssrc_pkg::S_RAMP_DOWN : pssrc_pkg::S_OFF;
        end
      end
      pssrc_pkg::S_RAMP_DOWN: begin
        if (target_on) begin
          ramp_load = 1'b1;
          state_nxt = pssrc_pkg::S_RAMP_UP;
        end else if (ramp_exp) begin
          state_nxt = pssrc_pkg::S_OFF;
        end
      end
      pssrc_pkg::S_FAULT: begin
        if (wait_exp) begin
          state_nxt = pssrc_pkg::S_OFF;
        end
      end
    endcase
    // a back-end error overrides any active phase
    if (fault_s && (state_r != pssrc_pkg::S_OFF) && (state_r != pssrc_pkg::S_FAULT)) begin
      state_nxt = pssrc_pkg::S_FAULT;
      ramp_load = 1'b0;
      wait_load = 1'b1;
    end
  end

  // state and stage control outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= pssrc_pkg::S_OFF;
      stage_r <= '0;
    end else begin
      state_r <= state_nxt;
      stage_r.stage_run <= (state_nxt == pssrc_pkg::S_RAMP_UP) ||
                           (state_nxt == pssrc_pkg::S_RUN) ||
                           (state_nxt == pssrc_pkg::S_RAMP_DOWN);
      stage_r.half_duty <= (state_nxt == pssrc_pkg::S_RAMP_UP) ||
                           (state_nxt == pssrc_pkg::S_RAMP_DOWN);
      stage_r.stage_reset <= (state_nxt == pssrc_pkg::S_FAULT);
    end
  end

  pssrc_tick_timer #(.W(TW)) u_ramp_tmr (
    .clk(clk),
    .nrst(nrst),
    .load(ramp_load),
    .load_val(ramp_len),
    .tick(tick_r),
    .busy(ramp_busy),
    .expire(ramp_exp)
  );

  pssrc_tick_timer #(.W(TW)) u_wait_tmr (
    .clk(clk),
    .nrst(nrst),
    .load(wait_load),
    .load_val(wait_len),
    .tick(tick_r),
    .busy(),
    .expire(wait_exp)
  );

  // event sources for the status register
  always_comb begin
    stat_set = '0;
    stat_set[pssrc_pkg::ST_RAMP_DONE] = ramp_exp && stage_r.half_duty; // only a live interval
    stat_set[pssrc_pkg::ST_TRIM_DONE] = trim_apply_r && osc_s && !trim_done_r;
    stat_set[pssrc_pkg::ST_FAULT] = wait_load;
    stat_set[pssrc_pkg::ST_RESTART] = (state_r == pssrc_pkg::S_FAULT) && wait_exp;
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      if (bus_req.wr && (bus_req.addr == pssrc_pkg::ADDR_STAT)) begin
        stat_r <= (stat_r & ~bus_req.wdata[pssrc_pkg::NSTAT-1:0]) | stat_set;
      end else begin
        stat_r <= stat_r | stat_set;
      end
      if (bus_req.wr && (bus_req.addr == pssrc_pkg::ADDR_MASK)) begin
        mask_r <= bus_req.wdata[pssrc_pkg::NSTAT-1:0];
      end
    end
  end

  // level interrupt
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        pssrc_pkg::ADDR_RAMP: rdata_r <= {ramp_dis_r, 2'b00, ramp_code_r};
        pssrc_pkg::ADDR_TRIM: rdata_r <= {1'b1, trim_done_r, 4'h0, trim_sel_r, 1'b0};
        pssrc_pkg::ADDR_WAIT: rdata_r <= {4'h0, wait_code_r};
        pssrc_pkg::ADDR_STAT: rdata_r <= {4'h0, stat_r};
        pssrc_pkg::ADDR_MASK: rdata_r <= {4'h0, mask_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_fault_halts_stage: assert property (
    (state_r == pssrc_pkg::S_RUN) && fault_s |=> stage_r.stage_reset && !stage_r.stage_run)
    else $error("back-end error did not halt the stage");
  chk_skip_half_duty: assert property (
    (state_r == pssrc_pkg::S_OFF) && target_on && !ramp_on && !fault_s
    |=> stage_r.stage_run && !stage_r.half_duty)
    else $error("zero period did not skip half duty");
  chk_start_ramps: assert property (
    (state_r == pssrc_pkg::S_OFF) && target_on && ramp_on |=> stage_r.half_duty ##1 ramp_busy)
    else $error("start did not enter half duty");
  chk_timer_disable: assert property (
    (state_r == pssrc_pkg::S_RUN) && !target_on && ramp_dis_r && !fault_s
    |=> state_r == pssrc_pkg::S_OFF && !stage_r.stage_run)
    else $error("disabled timer still ramped");
  chk_ramp_lengths: assert property (
    ((ramp_code_r == 5'h0F) |-> (ramp_len == 18'd1257)) and
    ((ramp_code_r == 5'h1F) |-> (ramp_len == 18'd131964)) and
    ((ramp_code_r == 5'h08) |-> (ramp_len == 18'd165)))
    else $error("wrong start/stop interval");
  chk_wait_lengths: assert property (
    ((wait_code_r >= 4'hA) |-> (wait_len == 18'd14960)) and
    ((wait_code_r == 4'h2) |-> (wait_len == 18'd2990)))
    else $error("wrong back-end wait");
  chk_wait_once: assert property (
    wait_lock_r && wr_wait |=> $stable(wait_code_r))
    else $error("wait register took a second write");
  chk_trim_apply: assert property (
    wr_trim && (bus_req.wdata == 8'h00) |=> ##1 trim_apply_r)
    else $error("factory trim not applied");
  chk_trim_flag: assert property (
    $rose(trim_done_r) |-> $past(trim_apply_r && osc_s))
    else $error("trim done without trim");
  chk_restart: assert property (
    (state_r == pssrc_pkg::S_FAULT) && wait_exp |=> (state_r == pssrc_pkg::S_OFF) and
    (target_on |=> state_r != pssrc_pkg::S_OFF))
    else $error("no restart after back-end wait");

  cov_ramp_up_done: cover property (
    (state_r == pssrc_pkg::S_RAMP_UP) ##1 (state_r == pssrc_pkg::S_RUN));
  cov_fault_restart: cover property (
    (state_r == pssrc_pkg::S_FAULT) ##1 (state_r == pssrc_pkg::S_OFF));
  cov_trim_done: cover property ($rose(trim_done_r));
  cov_ramp_down_done: cover property (
    (state_r == pssrc_pkg::S_RAMP_DOWN) ##1 (state_r == pssrc_pkg::S_OFF));

endmodule : pssrc_ctrl

// >>> pssrc_far_model.sv
// far-side stand-in: oscillator trim status and power stage error line.
// assumes the controller outputs are registered on the same clock.
`timescale 1ns/1ps
module pssrc_far_model #(
  parameter int TRIM_LAT = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic trim_apply,
  input wire logic stage_reset,
  input wire logic fault_cmd,
  output logic osc_trim_ready,
  output logic backend_fault
);
  int trim_cnt;
  // oscillator settles a fixed time after factory trim is applied
  always_ff @(posedge clk) begin
    if (!nrst || !trim_apply) trim_cnt <= 0;
    else if (trim_cnt < TRIM_LAT) trim_cnt <= trim_cnt + 1;
  end
  assign osc_trim_ready = (trim_cnt == TRIM_LAT);
  // error stays raised until the stage is put into reset
  always_ff @(posedge clk) begin
    if (!nrst || stage_reset) backend_fault <= 1'b0;
    else if (fault_cmd) backend_fault <= 1'b1;
  end
endmodule : pssrc_far_model

// >>> tb_top.sv
// self-checking bench for the start/stop, trim and fault recovery controller.
// assumes a tick of two cycles instead of 2000, so every interval is a thousand times shorter.
`timescale 1ns/1ps
module tb_top;
  localparam int T = 2;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  pssrc_pkg::pssrc_bus_req_t req = '0;
  logic [7:0] rdata;
  logic pin = 1'b0;
  logic shut = 1'b0;
  logic fault_cmd = 1'b0;
  logic fault;
  logic trim_rdy;
  pssrc_pkg::pssrc_stage_t stage;
  logic trim_apply;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  // period settings and expected intervals in 0.1 ms units
  logic [7:0] ramp_code [6] = '{8'h00, 8'h8F, 8'h08, 8'h0B, 8'h0F, 8'h10};
  int ramp_len [6] = '{0, 0, 165, 404, 1257, 1646};
  int wait_len [14] = '{2990, 4490, 5980, 7480, 8980, 10470, 11970, 13460,
    14960, 14960, 14960, 14960, 14960, 14960};

  always #25 clk = ~clk;

  pssrc_ctrl #(.TICK_CYCLES(T)) dut (.clk(clk), .nrst(nrst), .bus_req(req), .rdata_r(rdata),
    .powerdown_pin_state(pin), .all_ch_shutdown(shut), .backend_fault(fault),
    .osc_trim_ready(trim_rdy), .stage_r(stage), .trim_apply_r(trim_apply), .irq_r(irq));
  pssrc_far_model far (.clk(clk), .nrst(nrst), .trim_apply(trim_apply),
    .stage_reset(stage.stage_reset), .fault_cmd(fault_cmd), .osc_trim_ready(trim_rdy),
    .backend_fault(fault));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk("reg_read", d, exp);
  endtask : rc

  function automatic logic lvl(input int sel);
    return sel ? stage.stage_reset : stage.half_duty;
  endfunction : lvl

  // interval length is approximate, so accept a small window
  function automatic int fit(input int n, input int e);
    if (e == 0) return n;
    return (n >= e * T - 8 && n <= e * T + T + 8) ? e * T : n;
  endfunction : fit

  // cycles a stage output stays high, zero if it never rises
  task automatic span(input int sel, output int n);
    n = 0;
    for (int i = 0; i < 30 && !lvl(sel); i++) begin
      @(posedge clk);
      #1;
    end
    while (lvl(sel)) begin
      @(posedge clk);
      #1 n++;
      if (n > 40000) begin
        mismatches++;
        close_out();
      end
    end
  endtask : span

  initial begin
    logic [7:0] d;
    int n;
    int wc;
    int k;
    void'($urandom(32'h1223FB04));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // register reset values and an unmapped place
    rc(8'h1A, 8'h0F);
    rc(8'h1B, 8'h82);
    rc(8'h1C, 8'h02);
    rc(8'h30, 8'h00);
    $display("test reset_values done");
    // factory trim with its status bit unmasked
    wr(8'h1E, 8'h02);
    wr(8'h1B, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("trim_apply", trim_apply, 1);
    k = 0;
    do begin
      rd(8'h1B, d);
      k++;
    end while (!d[6] && k < 40);
    if (!d[6]) begin
      mismatches++;
      close_out();
    end
    chk("trim_reg", d, 8'hC0);
    @(posedge clk);
    #1 chk("irq_trim", irq, 1);
    wr(8'h1D, 8'h0F);
    repeat (2) @(posedge clk);
    #1 chk("irq_clear", irq, 0);
    $display("test trim done");
    // start/stop interval per setting, random stop cause
    for (int i = 0; i < 6; i++) begin
      wr(8'h1A, ramp_code[i]);
      pin <= 1'b1;
      shut <= 1'b0;
      span(0, n);
      chk("ramp_up", fit(n, ramp_len[i]), ramp_len[i] * T);
      chk("run", {stage.stage_run, stage.half_duty}, 2'b10);
      @(posedge clk);
      if ($urandom_range(1, 0) == 1) pin <= 1'b0;
      else shut <= 1'b1;
      span(0, n);
      chk("ramp_dn", fit(n, ramp_len[i]), ramp_len[i] * T);
      repeat (3) @(posedge clk);
      #1 chk("off", stage, 3'b000);
    end
    // reversal mid-interval starts a full interval the other way
    wr(8'h1A, 8'h08);
    shut <= 1'b0;
    pin <= 1'b1;
    repeat (100) @(posedge clk);
    shut <= 1'b1;
    span(0, n);
    chk("ramp_rev", fit(n, 165), 165 * T);
    chk("irq_masked", irq, 0);
    rc(8'h1D, 8'h01);
    wr(8'h1A, 8'hEF);
    rc(8'h1A, 8'h8F);
    $display("test ramps done");
    // back-end fault: stage held in reset for the wait, then restarted
    wc = $urandom_range(15, 2);
    wr(8'h1C, 8'(wc));
    wr(8'h1C, 8'(wc) ^ 8'h01);
    rc(8'h1C, 8'(wc));
    wr(8'h1E, 8'h0F);
    wr(8'h1D, 8'h0F);
    wr(8'h1A, 8'h00);
    pin <= 1'b1;
    shut <= 1'b0;
    repeat (10) @(posedge clk);
    fault_cmd <= 1'b1;
    @(posedge clk);
    fault_cmd <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("halt", {stage.stage_run, stage.stage_reset}, 2'b01);
    span(1, n);
    chk("fault_wait", fit(n, wait_len[wc-2]), wait_len[wc-2] * T);
    repeat (4) @(posedge clk);
    #1 chk("restart", stage.stage_run, 1);
    rd(8'h1D, d);
    chk("fault_stat", d & 8'h0C, 8'h0C);
    chk("irq_fault", irq, 1);
    wr(8'h1D, 8'h0F);
    repeat (2) @(posedge clk);
    #1 chk("irq_fault_clr", irq, 0);
    $display("test fault done");
    close_out();
  end
endmodule : tb_top
